// >>> design/fbp_flash_ctrl.sv
// flash array controller with block erase, program and region protection
`timescale 1ns/1ns
`default_nettype none
// Operation
// - The array holds 32 KB and every address across that range is decoded.
// - The array erases in 1-KB units, each unit erased alone without touching others.
// - An erased unit reads back all ones in every word.
// - Protection is set per 2-KB region covering two adjacent erase units.
// - A read-only region refuses erase and program and stays unchanged, but reads are allowed.
// - An execute-only region also refuses erase and program.
// - An execute-only region answers instruction fetches only, denying data and debug reads.
// - Allowed reads answer one cycle after the request with no wait states.
module fbp_flash_ctrl #(
	parameter int NUM_WORDS = fbp_pkg::FLASH_BYTES / 4
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire fbp_pkg::fbp_rd_req_s rd_req,
	output fbp_pkg::fbp_rd_rsp_s rd_rsp,
	input wire logic prog_valid,
	input wire logic [fbp_pkg::ADDR_W-1:0] prog_addr,
	input wire logic [fbp_pkg::WORD_W-1:0] prog_data,
	input wire logic erase_valid,
	input wire logic [fbp_pkg::UNIT_W-1:0] erase_unit,
	input wire logic [2*fbp_pkg::NUM_REGIONS-1:0] region_mode,
	input wire logic viol_clear,
	output logic viol_flag,
	output logic busy,
	output logic op_done
);
	localparam int WA = fbp_pkg::WORD_ADDR_W;
	localparam int OW = fbp_pkg::UNIT_OFS_W;
	localparam logic [OW-1:0] LAST_OFS = OW'(fbp_pkg::WORDS_PER_UNIT - 1);

	// the address split below is fixed, so refuse any size it cannot index
	if (NUM_WORDS != fbp_pkg::FLASH_BYTES / 4) begin : g_bad_words
		$error("fbp_flash_ctrl: NUM_WORDS must cover the whole array");
	end
	if (fbp_pkg::WORDS_PER_UNIT != 2 ** OW) begin : g_bad_unit
		$error("fbp_flash_ctrl: unit offset width does not match unit size");
	end
	if (fbp_pkg::REGION_BYTES != 2 * fbp_pkg::UNIT_BYTES) begin : g_bad_region
		$error("fbp_flash_ctrl: a region must hold exactly two erase units");
	end

	// ----------------------------------------------------------------
	// protection decode
	// ----------------------------------------------------------------
	// region index is the top address bits, so both units of a pair share it
	function automatic logic [1:0] mode_of(input logic [fbp_pkg::ADDR_W-1:0] a,
		input logic [2*fbp_pkg::NUM_REGIONS-1:0] m);
		logic [fbp_pkg::REGION_W-1:0] r;
		r = a[fbp_pkg::ADDR_W-1 -: fbp_pkg::REGION_W];
		mode_of = m[2*r +: 2];
	endfunction

	function automatic logic alter_ok(input logic [1:0] md);
		alter_ok = (md == fbp_pkg::MODE_OPEN);
	endfunction

	function automatic logic read_ok(input logic [1:0] md, input logic [1:0] src);
		read_ok = (md != fbp_pkg::MODE_EXEC_ONLY) || (src == fbp_pkg::REQ_FETCH);
	endfunction

	// ----------------------------------------------------------------
	// region decode
	// ----------------------------------------------------------------
	logic [fbp_pkg::NUM_REGIONS-1:0] region_open;

	// one open bit per 2 KB region; both units of a pair read the same bit
	for (genvar g = 0; g < fbp_pkg::NUM_REGIONS; g++) begin : g_region
		assign region_open[g] = alter_ok(region_mode[2*g +: 2]);
	end

	// ----------------------------------------------------------------
	// request qualification
	// ----------------------------------------------------------------
	logic [fbp_pkg::REGION_W-1:0] prog_region;
	logic [fbp_pkg::REGION_W-1:0] erase_region;
	logic [1:0] rd_mode;
	logic rd_deny;
	logic prog_deny;
	logic erase_deny;

	assign prog_region = prog_addr[fbp_pkg::ADDR_W-1 -: fbp_pkg::REGION_W];
	assign erase_region = erase_unit[fbp_pkg::UNIT_W-1 -: fbp_pkg::REGION_W];
	assign rd_mode = mode_of(rd_req.addr, region_mode);
	// only the fetch path may look into an execute-only region
	assign rd_deny = rd_req.valid && !read_ok(rd_mode, rd_req.source);
	assign prog_deny = prog_valid && !region_open[prog_region];
	assign erase_deny = erase_valid && !region_open[erase_region];

	// ----------------------------------------------------------------
	// erase and program sequencer
	// ----------------------------------------------------------------
	logic [fbp_pkg::WORD_W-1:0] mem_q [NUM_WORDS];
	fbp_pkg::fbp_state_e state_q;
	fbp_pkg::fbp_state_e state_d;
	logic [OW-1:0] ofs_q;
	logic [OW-1:0] ofs_d;
	logic [fbp_pkg::UNIT_W-1:0] unit_q;
	logic [fbp_pkg::UNIT_W-1:0] unit_d;
	logic busy_d;
	logic done_d;
	logic wr_en;
	logic [WA-1:0] wr_idx;
	logic [fbp_pkg::WORD_W-1:0] wr_data;
	logic [fbp_pkg::WORD_W-1:0] prog_old;

	assign prog_old = mem_q[prog_addr[fbp_pkg::ADDR_W-1:2]];

	always_comb begin
		state_d = state_q;
		ofs_d = ofs_q;
		unit_d = unit_q;
		wr_en = 1'b0;
		wr_idx = prog_addr[fbp_pkg::ADDR_W-1:2];
		wr_data = prog_data;
		done_d = 1'b0;
		case (state_q)
			fbp_pkg::FBP_IDLE: begin
				// an allowed erase wins a tie; a program in the same cycle is dropped
				if (erase_valid && !erase_deny) begin
					state_d = fbp_pkg::FBP_ERASE;
					unit_d = erase_unit;
					ofs_d = '0;
				end else if (prog_valid && !prog_deny) begin
					// flash program can only clear bits
					wr_en = 1'b1;
					wr_data = prog_old & prog_data;
					done_d = 1'b1;
				end
			end
			fbp_pkg::FBP_ERASE: begin
				// one word per cycle, only within the chosen unit
				wr_en = 1'b1;
				wr_idx = {unit_q, ofs_q};
				wr_data = fbp_pkg::ERASED_WORD;
				ofs_d = ofs_q + OW'(1);
				if (ofs_q == LAST_OFS) begin
					state_d = fbp_pkg::FBP_IDLE;
					done_d = 1'b1;
				end
			end
			default: begin
				state_d = fbp_pkg::FBP_IDLE;
			end
		endcase
		busy_d = (state_d != fbp_pkg::FBP_IDLE);
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_q <= fbp_pkg::FBP_IDLE;
			ofs_q <= '0;
			unit_q <= '0;
			busy <= 1'b0;
			op_done <= 1'b0;
		end else begin
			state_q <= state_d;
			ofs_q <= ofs_d;
			unit_q <= unit_d;
			busy <= busy_d;
			op_done <= done_d;
		end
	end

	// ----------------------------------------------------------------
	// read response
	// ----------------------------------------------------------------
	fbp_pkg::fbp_rd_rsp_s rsp_d;

	// reads see the array directly, so they carry on during an erase
	always_comb begin
		rsp_d.valid = rd_req.valid;
		rsp_d.denied = rd_deny;
		rsp_d.data = mem_q[rd_req.addr[fbp_pkg::ADDR_W-1:2]];
		if (rd_deny) begin
			// a denied read returns zero so nothing leaks
			rsp_d.data = '0;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rd_rsp <= '0;
		end else begin
			rd_rsp <= rsp_d;
		end
	end

	// ----------------------------------------------------------------
	// violation flag
	// ----------------------------------------------------------------
	logic viol_d;

	always_comb begin
		viol_d = viol_flag;
		if (viol_clear) begin
			viol_d = 1'b0;
		end
		// set wins over clear so a refusal in the clearing cycle is kept
		if (rd_deny || prog_deny || erase_deny) begin
			viol_d = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			viol_flag <= 1'b0;
		end else begin
			viol_flag <= viol_d;
		end
	end

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	// array content has no reset, like real flash; it starts unknown
	always_ff @(posedge sys_clk) begin
		if (wr_en) begin
			mem_q[wr_idx] <= wr_data;
		end
	end
endmodule // fbp_flash_ctrl
`default_nettype wire

// >>> inc/fbp_pkg.sv
// package for the flash block erase and protection controller
package fbp_pkg;
	localparam int FLASH_BYTES = 32768;
	localparam int UNIT_BYTES = 1024;
	localparam int REGION_BYTES = 2048;
	localparam int ADDR_W = 15;
	localparam int WORD_W = 32;
	localparam int WORD_ADDR_W = ADDR_W - 2;
	localparam int UNIT_W = 5;
	localparam int REGION_W = 4;
	localparam int NUM_REGIONS = FLASH_BYTES / REGION_BYTES;
	localparam int WORDS_PER_UNIT = UNIT_BYTES / 4;
	localparam int UNIT_OFS_W = 8;
	localparam logic [WORD_W-1:0] ERASED_WORD = 32'hFFFFFFFF;
	localparam logic [1:0] MODE_OPEN = 2'h0;
	localparam logic [1:0] MODE_READ_ONLY = 2'h1;
	localparam logic [1:0] MODE_EXEC_ONLY = 2'h2;
	localparam logic [1:0] REQ_FETCH = 2'h0;
	localparam logic [1:0] REQ_DATA = 2'h1;
	localparam logic [1:0] REQ_DEBUG = 2'h2;

	typedef struct packed {
		logic valid;
		logic [1:0] source;
		logic [ADDR_W-1:0] addr;
	} fbp_rd_req_s;

	typedef struct packed {
		logic valid;
		logic [WORD_W-1:0] data;
		logic denied;
	} fbp_rd_rsp_s;

	typedef enum logic [1:0] {
		FBP_IDLE,
		FBP_ERASE
	} fbp_state_e;
endpackage

// >>> sim/fbp_flash_ctrl_properties.sv
// checker for the flash controller ports
`timescale 1ns/1ns
`default_nettype none
module fbp_flash_ctrl_props (
	input wire logic sys_clk,
	input wire logic rst,
	input wire fbp_pkg::fbp_rd_req_s rd_req,
	input wire fbp_pkg::fbp_rd_rsp_s rd_rsp,
	input wire logic erase_valid,
	input wire logic [4:0] erase_unit,
	input wire logic [31:0] region_mode,
	input wire logic viol_clear,
	input wire logic viol_flag,
	input wire logic busy,
	input wire logic op_done
);
	logic [1:0] rm, em;
	assign rm = region_mode[{rd_req.addr[14:11], 1'b0} +: 2];
	assign em = region_mode[{erase_unit[4:1], 1'b0} +: 2];
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	chk_rd_answer: assert property (rd_req.valid |=> rd_rsp.valid)
		else $error("read not answered");
	chk_exec_deny: assert property (rd_req.valid && rd_req.source != 2'h0 && rm == 2'h2
		|=> rd_rsp.denied && rd_rsp.data == 32'h0) else $error("exec read leaked");
	chk_read_allow: assert property (rd_req.valid && (rd_req.source == 2'h0 || rm != 2'h2)
		|=> !rd_rsp.denied) else $error("read wrongly denied");
	chk_viol_set: assert property (rd_rsp.denied |-> viol_flag)
		else $error("flag missing");
	chk_viol_hold: assert property (viol_flag && !viol_clear |=> viol_flag)
		else $error("flag lost");
	chk_erase_start: assert property (erase_valid && !busy && em == 2'h0 |=> busy)
		else $error("erase not started");
	chk_erase_refuse: assert property (erase_valid && !busy && em != 2'h0
		|=> !busy && viol_flag) else $error("erase not refused");
	chk_erase_end: assert property ($fell(busy) |-> op_done)
		else $error("no done");
	cover property (rd_rsp.denied);
	cover property ($fell(busy));
	cover property (viol_flag && viol_clear);
endmodule // fbp_flash_ctrl_props
bind fbp_flash_ctrl fbp_flash_ctrl_props i_fbp_flash_ctrl_props (.sys_clk, .rst, .rd_req,
	.rd_rsp, .erase_valid, .erase_unit, .region_mode, .viol_clear, .viol_flag, .busy, .op_done);
`default_nettype wire

// >>> sim/fbp_requester.sv
// read requester standing in for fetch, data bus and debugger
`timescale 1ns/1ns
`default_nettype none
module fbp_requester (
	input wire logic go,
	input wire logic [1:0] src,
	input wire logic [14:0] addr,
	output fbp_pkg::fbp_rd_req_s rd_req
);
	// released lines invert so a stale request never looks valid data
	assign rd_req = go ? {1'b1, src, addr} : {1'b0, ~src, ~addr};
endmodule // fbp_requester
`default_nettype wire

// >>> sim/fbp_flash_ctrl_test.sv
// testbench for the flash controller
`timescale 1ns/1ns
`default_nettype none
module fbp_flash_ctrl_test;
	logic sys_clk = 0, rst = 1, go = 0, pv = 0, ev = 0, vc = 0, vf, bz, od;
	logic [1:0] s = 0, src_r = 0;
	logic [4:0] eu = 0;
	logic [14:0] a = 0;
	logic [31:0] pd = 0, rm = 0, w, seed = 32'h8EA8AFDF;
	fbp_pkg::fbp_rd_req_s rq;
	fbp_pkg::fbp_rd_rsp_s rs;
	int mismatches = 0, cmp_count = 0, n;
	always #4 sys_clk = ~sys_clk;
	fbp_requester i_fbp_requester (.go(go), .src(s), .addr(a), .rd_req(rq));
	fbp_flash_ctrl i_fbp_flash_ctrl (.sys_clk(sys_clk), .rst(rst), .rd_req(rq), .rd_rsp(rs),
		.prog_valid(pv), .prog_addr(a), .prog_data(pd), .erase_valid(ev), .erase_unit(eu),
		.region_mode(rm), .viol_clear(vc), .viol_flag(vf), .busy(bz), .op_done(od));
	task ck(input string nm, input logic [31:0] e, input logic [31:0] v);
		cmp_count++;
		if (e !== v) begin
			$display("unexpected %s exp %h seen %h", nm, e, v);
			mismatches++;
		end
	endtask
	task rd(input logic [1:0] src, input logic [31:0] e, input logic d);
		@(negedge sys_clk) go = 1;
		s = src;
		@(negedge sys_clk) go = 0;
		ck("valid", 1, rs.valid);
		ck("data", e, rs.data);
		ck("denied", d, rs.denied);
	endtask
	task er(input logic [4:0] u, input int e);
		@(negedge sys_clk) ev = 1;
		eu = u;
		@(negedge sys_clk) ev = 0;
		n = 0;
		while (bz === 1'b1 && n < 300) begin
			@(negedge sys_clk);
			n++;
		end
		ck("erase cycles", e, n);
		ck("done", e > 0, od);
		if (n >= 300)
			print_verdict;
	endtask
	task pg(input logic [31:0] d, input logic ok);
		@(negedge sys_clk) pv = 1;
		pd = d;
		@(negedge sys_clk) pv = 0;
		ck("prog done", ok, od);
	endtask
	function automatic logic exp_den(input logic [1:0] m, input logic [1:0] src);
		exp_den = (m == fbp_pkg::MODE_EXEC_ONLY) && (src != fbp_pkg::REQ_FETCH);
	endfunction
	function automatic logic [31:0] exp_data(input logic [1:0] m, input logic [1:0] src);
		exp_data = exp_den(m, src) ? 32'h0 : fbp_pkg::ERASED_WORD;
	endfunction
	function automatic int exp_cycles(input logic [1:0] m);
		exp_cycles = (m == fbp_pkg::MODE_OPEN) ? fbp_pkg::WORDS_PER_UNIT : 0;
	endfunction
	task print_verdict;
		$display("mismatches %0d comparisons %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(negedge sys_clk);
		rst = 0;
		a = {5'h1F, 8'($random(seed)), 2'h0};
		w = $random(seed);
		er(5'h1F, fbp_pkg::WORDS_PER_UNIT);
		rd(fbp_pkg::REQ_FETCH, fbp_pkg::ERASED_WORD, 0);
		pg(w, 1);
		rd(2'h1, w, 0);
		er(5'h1E, fbp_pkg::WORDS_PER_UNIT);
		rd(2'h2, w, 0);
		rm[31:30] = 2'h1;
		er(5'h1F, 0);
		pg(32'h0, 0);
		rd(2'h1, w, 0);
		ck("flag", 1, vf);
		vc = 1;
		@(negedge sys_clk) vc = 0;
		ck("flag", 0, vf);
		rm[31:30] = 2'h2;
		er(5'h1E, 0);
		pg(32'h0, 0);
		rd(2'h0, w, 0);
		// clear held through a denied read: the new refusal must survive
		vc = 1;
		rd(2'h1, 0, 1);
		vc = 0;
		ck("flag", 1, vf);
		rd(2'h2, 0, 1);
		// random modes and sources over the erased unit beside the programmed one
		for (int i = 0; i < 48; i++) begin
			a = {5'h1E, 8'($random(seed)), 2'($random(seed))};
			rm[31:30] = 2'($random(seed));
			src_r = 2'($random(seed));
			er(5'h1E, exp_cycles(rm[31:30]));
			rd(src_r, exp_data(rm[31:30], src_r), exp_den(rm[31:30], src_r));
		end
		print_verdict;
	end
endmodule // fbp_flash_ctrl_test
`default_nettype wire
